// >>> tb/dmr_host_model.sv
// host side model that reads and writes the monitor bank
`timescale 1ns/1ps
module dmr_host_model
(
   input  wire        clk,
   input  wire        host_rvalid,
   input  wire [15:0] host_rdata,
   output reg  [15:0] host_addr,
   output reg         host_rd,
   output reg         host_wr,
   output reg  [15:0] host_wdata
);
   initial
   begin
      host_addr = 16'h0000;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_wdata = 16'h0000;
   end
   // one read; released address shows its inverse so stale values never pass
   task rd_word(input [15:0] a, output [15:0] d);
      begin
         @(posedge clk);
         host_addr <= a;
         host_rd <= 1'b1;
         @(posedge clk);
         host_rd <= 1'b0;
         host_addr <= ~a;
         @(posedge clk);
         d = (host_rvalid === 1'b1) ? host_rdata : 16'hxxxx;
      end
   endtask
   // one word write, a single strobe cycle
   task wr_word(input [15:0] a, input [15:0] v);
      begin
         @(posedge clk);
         host_addr <= a;
         host_wdata <= v;
         host_wr <= 1'b1;
         @(posedge clk);
         host_wr <= 1'b0;
         host_addr <= ~a;
         host_wdata <= ~v;
      end
   endtask
endmodule

// >>> tb/dmr_readout_checker.sv
// concurrent checks on the monitor bank host port
`timescale 1ns/1ps
`include "dmr_defs.vh"
module dmr_readout_checker
#(
   parameter GATE_CYCLES = 100,
   parameter DATA_W      = 16
)
(
   input wire              clk,
   input wire              rstn,
   input wire [1:0]        run_dir,
   input wire [1:0]        speed_trend,
   input wire              bus_undervoltage,
   input wire [58:0]       function_active,
   input wire              timed_run,
   input wire [15:0]       time_left_tenths,
   input wire [15:0]       host_addr,
   input wire              host_rd,
   input wire              host_wr,
   input wire [DATA_W-1:0] host_wdata,
   input wire [DATA_W-1:0] host_rdata,
   input wire              host_rvalid
);
   reg [DATA_W-1:0] mir;
   // shadow of the reference word, only the reference address may change it
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         mir <= 16'h0000;
      else if (host_wr && host_addr == `DMR_ADDR_COMM_REF)
         mir <= host_wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // a read is answered exactly one cycle later, never otherwise
   chk_read_answer: assert property (host_rd |=> host_rvalid)
      else $error("read not answered in one cycle");
   chk_valid_pulse: assert property (!host_rd |=> !host_rvalid)
      else $error("answer without a read");
   chk_unmapped_zero: assert property (host_rd && host_addr == 16'h0123
      |=> host_rdata == 16'h0000)
      else $error("unmapped read not zero");
   // readouts are a registered copy, so data lags the inputs two edges
   chk_dir_field: assert property (host_rd && host_addr == `DMR_ADDR_STATE_WORD
      |=> host_rdata[1:0] == $past(run_dir, 2))
      else $error("direction field wrong");
   chk_trend_field: assert property (host_rd && host_addr == `DMR_ADDR_STATE_WORD
      |=> host_rdata[3:2] == $past(speed_trend, 2))
      else $error("trend field wrong");
   chk_undervolt_bit: assert property (host_rd && host_addr == `DMR_ADDR_STATE_WORD
      |=> host_rdata[4] == $past(bus_undervoltage, 2) && host_rdata[15:5] == 11'h000)
      else $error("undervoltage bit wrong");
   chk_act_low: assert property (host_rd && host_addr == `DMR_ADDR_ACT_LOW
      |=> host_rdata == $past(function_active[15:0], 2))
      else $error("low activity word wrong");
   chk_act_high: assert property (host_rd && host_addr == `DMR_ADDR_ACT_HIGH_TOP
      |=> host_rdata == {13'h0000, $past(function_active[58:56], 2)})
      else $error("top activity word wrong");
   chk_mirror_echo: assert property (host_rd && host_addr == `DMR_ADDR_COMM_MIRROR
      |=> host_rdata == $past(mir))
      else $error("reference mirror wrong");
   chk_time_gate: assert property (host_rd && host_addr == `DMR_ADDR_REMAIN_TIME
      |=> host_rdata == (!$past(timed_run, 2) ? 16'h0000 :
      ($past(time_left_tenths, 2) > 16'hFDE8 ? 16'hFDE8 : $past(time_left_tenths, 2))))
      else $error("remaining time wrong");
   cover property (host_rd && host_addr == `DMR_ADDR_QUAD_POS);
   cover property (host_wr && host_addr == `DMR_ADDR_COMM_REF);
   cover property (host_rd && host_addr == `DMR_ADDR_STATE_WORD && bus_undervoltage);
endmodule

bind dmr_readout dmr_readout_checker #(.GATE_CYCLES(GATE_CYCLES), .DATA_W(DATA_W)) u_chk
   (.clk(clk), .rstn(rstn), .run_dir(run_dir), .speed_trend(speed_trend),
    .bus_undervoltage(bus_undervoltage), .function_active(function_active),
    .timed_run(timed_run), .time_left_tenths(time_left_tenths), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

// >>> tb/tb_dmr_readout.sv
// self-checking testbench for the drive monitor readout bank
`timescale 1ns/1ps
`include "dmr_defs.vh"
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) \
   begin mismatches = mismatches + 1; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_dmr_readout;
   reg                clk = 1'b0;
   reg                rstn, enc_a, enc_b, enc_z, hs, pulse_en, uv, timed_run, tick;
   reg         [1:0]  run_dir, speed_trend, pc;
   reg         [3:0]  dec;
   reg         [16:0] fb, encs;
   reg         [15:0] ppm, tleft, ex;
   reg         [58:0] fa;
   wire        [15:0] host_addr, host_wdata, host_rdata;
   wire               host_rd, host_wr, host_rvalid;
   integer            mismatches = 0, check_count = 0, cyc = 0, q = 0, i;
   dmr_readout #(.GATE_CYCLES(100)) dut (.clk(clk), .rstn(rstn), .enc_a(enc_a),
      .enc_b(enc_b), .enc_z(enc_z), .high_speed_pulse_input(hs), .run_dir(run_dir),
      .speed_trend(speed_trend), .bus_undervoltage(uv), .speed_decimal_places_setting(dec),
      .feedback_freq_centi_hz(fb), .encoder_freq_centi_hz(encs), .pulses_per_metre(ppm),
      .function_active(fa), .timed_run(timed_run), .time_left_tenths(tleft),
      .energy_tick(tick), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
   dmr_host_model host (.clk(clk), .host_rvalid(host_rvalid), .host_rdata(host_rdata),
      .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata));
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // pulse source, period four cycles, so exactly 25 rises per 100-cycle gate
   always @(posedge clk)
   begin
      pc <= pc + 2'b01;
      hs <= pulse_en & pc[1];
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   task rc(input [15:0] a, input [15:0] e);
      reg [15:0] d;
      begin
         host.rd_word(a, d);
         `CHK(d, e)
      end
   endtask
   // n quadrature steps in direction dirn; gray order 00 01 11 10 counts up
   task step(input integer dirn, input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1)
         begin
            q = (q + dirn + 4) % 4;
            @(posedge clk);
            {enc_a, enc_b} <= (q == 0) ? 2'b00 : (q == 1) ? 2'b01 : (q == 2) ? 2'b11 : 2'b10;
            repeat (2) @(posedge clk);
         end
      end
   endtask
   task zp;
      begin
         @(posedge clk) enc_z <= 1'b1;
         repeat (2) @(posedge clk);
         enc_z <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   task settle;
      repeat (3) @(posedge clk);
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial
   begin
      rstn = 1'b0; {enc_a, enc_b, enc_z, pulse_en, uv, timed_run, tick} = 7'h00;
      run_dir = 2'h0; speed_trend = 2'h0; pc = 2'h0; dec = 4'h2; fb = 17'h0_0000;
      encs = 17'h0_0000; ppm = 16'h03E8; tleft = 16'h0000; fa = 59'h000_0000_0000_0000;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      settle;
      rc(`DMR_ADDR_QUAD_POS, 16'h0000);
      rc(`DMR_ADDR_ENERGY_LOW, 16'h0000);
      rc(16'h0123, 16'h0000);
      step(1, 4); rc(`DMR_ADDR_QUAD_POS, 16'h0004);
      zp; rc(`DMR_ADDR_REV_COUNT, 16'h0001);
      step(-1, 8); rc(`DMR_ADDR_QUAD_POS, 16'hFFFC);
      zp; zp; rc(`DMR_ADDR_REV_COUNT, 16'hFFFF);
      step(1, 4); rc(`DMR_ADDR_QUAD_POS, 16'h0000);
      $display("test encoder done");
      pulse_en <= 1'b1;
      repeat (300) @(posedge clk);
      rc(`DMR_ADDR_PULSE_HZ, 16'h0019);
      rc(`DMR_ADDR_PULSE_KHZ, 16'h0002);
      rc(`DMR_ADDR_LINEAR_SPEED, 16'h000F);
      $display("test pulse done");
      for (i = 0; i < 18; i = i + 1)
      begin
         ex = 16'((i % 3) | (((i / 3) % 3) << 2) | ((i / 9) << 4));
         @(posedge clk);
         {uv, speed_trend, run_dir} <= ex[4:0];
         settle;
         rc(`DMR_ADDR_STATE_WORD, ex);
      end
      $display("test state done");
      fb <= 17'h0_3039; encs <= 17'h1_63C0; settle;
      rc(`DMR_ADDR_FB_SPEED, 16'h3039);
      rc(`DMR_ADDR_ENC_SPEED, 16'h8300);
      dec <= 4'h1; encs <= 17'h1_15A0; settle;
      rc(`DMR_ADDR_FB_SPEED, 16'h04D2);
      rc(`DMR_ADDR_ENC_SPEED, 16'hEC78);
      $display("test speed done");
      fa <= 59'h7A5_1234_ABCD_9876; settle;
      rc(`DMR_ADDR_ACT_LOW, fa[15:0]);
      rc(`DMR_ADDR_ACT_LOW_MID, fa[31:16]);
      rc(`DMR_ADDR_ACT_LOW_TOP, {8'h00, fa[39:32]});
      rc(`DMR_ADDR_ACT_HIGH, fa[55:40]);
      rc(`DMR_ADDR_ACT_HIGH_TOP, {13'h0000, fa[58:56]});
      $display("test activity done");
      host.wr_word(`DMR_ADDR_COMM_REF, 16'hD8F0);
      rc(`DMR_ADDR_COMM_MIRROR, 16'hD8F0);
      host.wr_word(`DMR_ADDR_COMM_MIRROR, 16'h1111);
      host.wr_word(`DMR_ADDR_QUAD_POS, 16'h1234);
      rc(`DMR_ADDR_COMM_MIRROR, 16'hD8F0);
      rc(`DMR_ADDR_QUAD_POS, 16'h0000);
      $display("test mirror done");
      tleft <= 16'h04D2; settle;
      rc(`DMR_ADDR_REMAIN_TIME, 16'h0000);
      timed_run <= 1'b1; settle;
      rc(`DMR_ADDR_REMAIN_TIME, 16'h04D2);
      tleft <= 16'hFFFF; settle;
      rc(`DMR_ADDR_REMAIN_TIME, 16'hFDE8);
      $display("test time done");
      repeat (10003)
      begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
      end
      settle;
      rc(`DMR_ADDR_ENERGY_LOW, 16'h0003);
      rc(`DMR_ADDR_ENERGY_HIGH, 16'h0001);
      $display("test energy done");
      complete_run;
   end
endmodule

// >>> verilog/dmr_defs.vh
// constants for the drive monitor readout bank
`ifndef DMR_DEFS_VH
`define DMR_DEFS_VH

// host addresses, monitor block base plus monitor index
`define DMR_ADDR_REMAIN_TIME   16'h7014
`define DMR_ADDR_PULSE_KHZ     16'h7012
`define DMR_ADDR_FB_SPEED      16'h7013
`define DMR_ADDR_LINEAR_SPEED  16'h7018
`define DMR_ADDR_PULSE_HZ      16'h701B
`define DMR_ADDR_COMM_MIRROR   16'h701C
`define DMR_ADDR_ENC_SPEED     16'h701D
`define DMR_ADDR_QUAD_POS      16'h7026
`define DMR_ADDR_ACT_LOW       16'h702B
`define DMR_ADDR_ACT_HIGH      16'h702C
`define DMR_ADDR_REV_COUNT     16'h703A
`define DMR_ADDR_STATE_WORD    16'h703D
`define DMR_ADDR_ENERGY_LOW    16'h704C
`define DMR_ADDR_ENERGY_HIGH   16'h704D
`define DMR_ADDR_ACT_LOW_MID   16'h7050
`define DMR_ADDR_ACT_LOW_TOP   16'h7051
`define DMR_ADDR_ACT_HIGH_TOP  16'h7052
// communication reference, the only writable address
`define DMR_ADDR_COMM_REF      16'h1000

// drive state word fields
`define DMR_ST_DIR_LSB         0
`define DMR_ST_TREND_LSB       2
`define DMR_ST_UNDERVOLT_BIT   4

// reset values
`define DMR_RST_WORD           16'h0000
`define DMR_RST_PPM            16'h03E8

// readout limits
`define DMR_TIME_MAX_TENTHS    16'hFDE8
`define DMR_SPEED2_LIMIT       17'sd32000
`define DMR_SPEED1_LIMIT       17'sd5000
`define DMR_ENERGY_LOW_MAX     16'h270F
`define DMR_PULSE_CNT_MAX      17'h1_86A0

// timing: pulse frequency gate
`define DMR_CLK_HZ             40000000
`define DMR_GATE_TIME_MS       1000
`define DMR_GATE_CYCLES        ((`DMR_CLK_HZ / 1000) * `DMR_GATE_TIME_MS)

`endif

// >>> verilog/dmr_quad_counter.v
// quadrature position and index revolution counters
`timescale 1ns/1ps
module dmr_quad_counter
#(
   parameter CNT_W = 16
)
(
   input  wire             clk,
   input  wire             rstn,
   input  wire             enc_a,
   input  wire             enc_b,
   input  wire             enc_z,
   output reg  [CNT_W-1:0] position,
   output reg  [CNT_W-1:0] revolutions
);

   reg prev_a;
   reg prev_b;
   reg prev_z;
   reg primed;
   reg last_up;
   wire moved   = (enc_a ^ prev_a) | (enc_b ^ prev_b);
   wire step_up = prev_a ^ enc_b;

   // every edge of a and b is one count; natural wrap of the counter
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prev_a      <= 1'b0;
         prev_b      <= 1'b0;
         prev_z      <= 1'b0;
         primed      <= 1'b0;
         last_up     <= 1'b1;
         position    <= {CNT_W{1'b0}};
         revolutions <= {CNT_W{1'b0}};
      end
      else
      begin
         prev_a <= enc_a;
         prev_b <= enc_b;
         prev_z <= enc_z;
         primed <= 1'b1;
         // first cycle only loads history, else the reset level miscounts
         if (primed && moved)
         begin
            last_up <= step_up;
            if (step_up)
               position <= position + 1'b1;
            else
               position <= position - 1'b1;
         end
         if (primed && enc_z && !prev_z)
         begin
            if (last_up)
               revolutions <= revolutions + 1'b1;
            else
               revolutions <= revolutions - 1'b1;
         end
      end
   end

endmodule

// >>> verilog/dmr_readout.v
// drive monitor readout bank with host read port
`timescale 1ns/1ps
`include "dmr_defs.vh"
module dmr_readout
#(
   parameter GATE_CYCLES = `DMR_GATE_CYCLES,
   parameter DATA_W      = 16
)
(
   input  wire                clk,
   input  wire                rstn,
   input  wire                enc_a,
   input  wire                enc_b,
   input  wire                enc_z,
   input  wire                high_speed_pulse_input,
   input  wire [1:0]          run_dir,
   input  wire [1:0]          speed_trend,
   input  wire                bus_undervoltage,
   input  wire [3:0]          speed_decimal_places_setting,
   input  wire signed [16:0]  feedback_freq_centi_hz,
   input  wire signed [16:0]  encoder_freq_centi_hz,
   input  wire [15:0]         pulses_per_metre,
   input  wire [58:0]         function_active,
   input  wire                timed_run,
   input  wire [15:0]         time_left_tenths,
   input  wire                energy_tick,
   input  wire [15:0]         host_addr,
   input  wire                host_rd,
   input  wire                host_wr,
   input  wire [DATA_W-1:0]   host_wdata,
   output reg  [DATA_W-1:0]   host_rdata,
   output reg                 host_rvalid
);

   wire [15:0] quadrature_position_count;
   wire [15:0] index_revolution_count;
   reg  [15:0] pulse_input_frequency_hz;
   reg  [15:0] pulse_input_frequency_khz;
   reg  [15:0] linear_speed_readout;
   reg  [15:0] feedback_speed_readout;
   reg  [15:0] encoder_speed_readout;
   reg  [15:0] comm_reference_mirror;
   reg  [15:0] remaining_run_time;
   reg  [15:0] energy_accum_low;
   reg  [15:0] energy_accum_high;
   reg  [15:0] drive_state_word;
   reg  [39:0] input_function_activity_low;
   reg  [18:0] input_function_activity_high;

   // position and revolution counting kept in its own leaf
   dmr_quad_counter #(.CNT_W(16)) u_quad
   (
      .clk         (clk),
      .rstn        (rstn),
      .enc_a       (enc_a),
      .enc_b       (enc_b),
      .enc_z       (enc_z),
      .position    (quadrature_position_count),
      .revolutions (index_revolution_count)
   );

   // pulse counting over a one second gate
   // the count runs on to 100 khz for the kilohertz readout, while the
   // hertz readout saturates at its 16-bit ceiling instead
   reg  [31:0] gate_cnt;
   reg  [16:0] pulse_cnt;
   reg         prev_pulse;
   wire        gate_end   = (gate_cnt == GATE_CYCLES - 1);
   wire        pulse_rise = high_speed_pulse_input & ~prev_pulse;
   wire        cnt_full   = (pulse_cnt >= `DMR_PULSE_CNT_MAX);
   wire [15:0] hz_sat     = pulse_cnt[16] ? 16'hFFFF : pulse_cnt[15:0];
   // tens of hertz, at most 10000, so the slice below never loses bits
   wire [16:0] khz_full   = pulse_cnt / 17'd10;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gate_cnt                  <= 32'h0000_0000;
         pulse_cnt                 <= 17'h0_0000;
         prev_pulse                <= 1'b0;
         pulse_input_frequency_hz  <= `DMR_RST_WORD;
         pulse_input_frequency_khz <= `DMR_RST_WORD;
      end
      else
      begin
         prev_pulse <= high_speed_pulse_input;
         if (gate_end)
         begin
            gate_cnt                  <= 32'h0000_0000;
            pulse_cnt                 <= {16'h0000, pulse_rise};
            pulse_input_frequency_hz  <= hz_sat;
            // units of 10 hz are kilohertz with two decimals
            pulse_input_frequency_khz <= khz_full[15:0];
         end
         else
         begin
            gate_cnt <= gate_cnt + 32'h0000_0001;
            if (pulse_rise && !cnt_full)
               pulse_cnt <= pulse_cnt + 17'h0_0001;
         end
      end
   end

   // linear speed: hz*60 pulses per minute over ppm in tenths, so hz*600/ppm
   // serial divider, one bit per cycle, trades area for 32 cycles latency
   reg  [31:0] div_num;
   reg  [15:0] div_den;
   reg  [31:0] div_quo;
   reg  [16:0] div_rem;
   reg  [5:0]  div_bits;
   reg         div_busy;
   wire [16:0] rem_shift = {div_rem[15:0], div_num[31]};
   wire        rem_ge    = (rem_shift >= {1'b0, div_den});
   wire [31:0] ppm_num   = {16'h0000, hz_sat} * 32'd600;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         div_num              <= 32'h0000_0000;
         div_den              <= `DMR_RST_PPM;
         div_quo              <= 32'h0000_0000;
         div_rem              <= 17'h0_0000;
         div_bits             <= 6'h00;
         div_busy             <= 1'b0;
         linear_speed_readout <= `DMR_RST_WORD;
      end
      else if (gate_end && !div_busy)
      begin
         div_num  <= ppm_num;
         // a zero setting would give an all-ones quotient, so it counts as one
         div_den  <= (pulses_per_metre == 16'h0000) ? 16'h0001 : pulses_per_metre;
         div_quo  <= 32'h0000_0000;
         div_rem  <= 17'h0_0000;
         div_bits <= 6'd32;
         div_busy <= 1'b1;
      end
      else if (div_busy)
      begin
         div_num  <= {div_num[30:0], 1'b0};
         div_rem  <= rem_ge ? (rem_shift - {1'b0, div_den}) : rem_shift;
         div_quo  <= {div_quo[30:0], rem_ge};
         div_bits <= div_bits - 6'd1;
         if (div_bits == 6'd1)
         begin
            div_busy <= 1'b0;
            // quotient saturates to the 16-bit readout
            linear_speed_readout <= (div_quo[30:15] != 16'h0000) ? 16'hFFFF :
                                    {div_quo[14:0], rem_ge};
         end
      end
   end

   // speed formatting from the decimal digit, clamped to its range
   // one decimal truncates toward zero and keeps the sign
   function [15:0] dmr_fmt_speed;
      input signed [16:0] centi;
      input               one_dec;
      reg   signed [16:0] v;
      begin
         v = one_dec ? (centi / 17'sd10) : centi;
         if (one_dec && v > `DMR_SPEED1_LIMIT)
            v = `DMR_SPEED1_LIMIT;
         else if (one_dec && v < -`DMR_SPEED1_LIMIT)
            v = -`DMR_SPEED1_LIMIT;
         else if (!one_dec && v > `DMR_SPEED2_LIMIT)
            v = `DMR_SPEED2_LIMIT;
         else if (!one_dec && v < -`DMR_SPEED2_LIMIT)
            v = -`DMR_SPEED2_LIMIT;
         dmr_fmt_speed = v[15:0];
      end
   endfunction

   // any digit other than one keeps the two-decimal format
   wire one_decimal = (speed_decimal_places_setting == 4'h1);

   // monitor snapshots and energy accumulation
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         feedback_speed_readout       <= `DMR_RST_WORD;
         encoder_speed_readout        <= `DMR_RST_WORD;
         remaining_run_time           <= `DMR_RST_WORD;
         drive_state_word             <= `DMR_RST_WORD;
         energy_accum_low             <= `DMR_RST_WORD;
         energy_accum_high            <= `DMR_RST_WORD;
         input_function_activity_low  <= 40'h00_0000_0000;
         input_function_activity_high <= 19'h0_0000;
      end
      else
      begin
         feedback_speed_readout <= dmr_fmt_speed(feedback_freq_centi_hz, one_decimal);
         encoder_speed_readout  <= dmr_fmt_speed(encoder_freq_centi_hz, one_decimal);
         // time left only during a timed run
         if (!timed_run)
            remaining_run_time <= `DMR_RST_WORD;
         else if (time_left_tenths > `DMR_TIME_MAX_TENTHS)
            remaining_run_time <= `DMR_TIME_MAX_TENTHS;
         else
            remaining_run_time <= time_left_tenths;
         drive_state_word <= `DMR_RST_WORD
            | ({14'h0000, run_dir} << `DMR_ST_DIR_LSB)
            | ({14'h0000, speed_trend} << `DMR_ST_TREND_LSB)
            | ({15'h0000, bus_undervoltage} << `DMR_ST_UNDERVOLT_BIT);
         // byte n holds functions 8n+1..8n+8, byte 0 is the rightmost digit
         input_function_activity_low  <= function_active[39:0];
         input_function_activity_high <= function_active[58:40];
         if (energy_tick)
         begin
            if (energy_accum_low == `DMR_ENERGY_LOW_MAX)
            begin
               energy_accum_low  <= `DMR_RST_WORD;
               energy_accum_high <= energy_accum_high + 16'h0001;
            end
            else
               energy_accum_low <= energy_accum_low + 16'h0001;
         end
      end
   end

   // host port: one write target, reads answered the cycle after the strobe
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         comm_reference_mirror <= `DMR_RST_WORD;
         host_rdata            <= {DATA_W{1'b0}};
         host_rvalid           <= 1'b0;
      end
      else
      begin
         // writes elsewhere, monitors included, fall through untouched
         if (host_wr && host_addr == `DMR_ADDR_COMM_REF)
            comm_reference_mirror <= host_wdata[15:0];
         // answer strobe follows every read by exactly one cycle
         host_rvalid <= host_rd;
         if (host_rd)
         begin
            if (host_addr == `DMR_ADDR_QUAD_POS)
               host_rdata <= quadrature_position_count;
            else if (host_addr == `DMR_ADDR_REV_COUNT)
               host_rdata <= index_revolution_count;
            else if (host_addr == `DMR_ADDR_PULSE_HZ)
               host_rdata <= pulse_input_frequency_hz;
            else if (host_addr == `DMR_ADDR_PULSE_KHZ)
               host_rdata <= pulse_input_frequency_khz;
            else if (host_addr == `DMR_ADDR_LINEAR_SPEED)
               host_rdata <= linear_speed_readout;
            else if (host_addr == `DMR_ADDR_FB_SPEED)
               host_rdata <= feedback_speed_readout;
            else if (host_addr == `DMR_ADDR_ENC_SPEED)
               host_rdata <= encoder_speed_readout;
            else if (host_addr == `DMR_ADDR_COMM_MIRROR)
               host_rdata <= comm_reference_mirror;
            else if (host_addr == `DMR_ADDR_REMAIN_TIME)
               host_rdata <= remaining_run_time;
            else if (host_addr == `DMR_ADDR_STATE_WORD)
               host_rdata <= drive_state_word;
            else if (host_addr == `DMR_ADDR_ENERGY_LOW)
               host_rdata <= energy_accum_low;
            else if (host_addr == `DMR_ADDR_ENERGY_HIGH)
               host_rdata <= energy_accum_high;
            else if (host_addr == `DMR_ADDR_ACT_LOW)
               host_rdata <= input_function_activity_low[15:0];
            else if (host_addr == `DMR_ADDR_ACT_LOW_MID)
               host_rdata <= input_function_activity_low[31:16];
            else if (host_addr == `DMR_ADDR_ACT_LOW_TOP)
               host_rdata <= {8'h00, input_function_activity_low[39:32]};
            else if (host_addr == `DMR_ADDR_ACT_HIGH)
               host_rdata <= input_function_activity_high[15:0];
            else if (host_addr == `DMR_ADDR_ACT_HIGH_TOP)
               host_rdata <= {13'h0000, input_function_activity_high[18:16]};
            else
               host_rdata <= {DATA_W{1'b0}}; // unmapped reads as zero
         end
      end
   end

endmodule
